// ### hdl/adc_pkg.sv
// package: register map, field layout and timing of the converter control block
// assumes: 8-bit registers on a 32-bit apb word each, one clock pclk
package adc_pkg;
    // ----------------------------------------------------------------
    // register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_RESULT_LOW = 10'h020;
    localparam logic [9:0] IDX_RESULT_HIGH = 10'h021;
    localparam logic [9:0] IDX_CONTROL = 10'h022;
    localparam logic [9:0] IDX_CLOCK_SELECT = 10'h023;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h024;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h025;
    localparam logic [11:0] ADDR_RESULT_LOW = {IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_CLOCK_SELECT = {IDX_CLOCK_SELECT, 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // ----------------------------------------------------------------
    // control, clock select and result register field positions
    // ----------------------------------------------------------------
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_CFG_LSB = 3;
    localparam int CTRL_DONE_BIT = 6;
    localparam int CTRL_START_BIT = 7;
    localparam int CSEL_TEST_BIT = 7;
    localparam int RES_LOW_LSB = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h40;
    localparam logic [2:0] CFG_NONE = 3'h0;

    // ----------------------------------------------------------------
    // conversion clock and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] DIV_SEL_2 = 2'h0;
    localparam logic [1:0] DIV_SEL_8 = 2'h1;
    localparam logic [1:0] DIV_SEL_32 = 2'h2;
    localparam logic [4:0] DIV_LAST_2 = 5'h01;
    localparam logic [4:0] DIV_LAST_8 = 5'h07;
    localparam logic [4:0] DIV_LAST_32 = 5'h1f;
    localparam logic [6:0] TAPS_SAMPLE = 7'h20;
    localparam logic [6:0] TAPS_TOTAL = 7'h50;
    localparam logic [1:0] TAPS_PER_BIT_LAST = 2'h3;
    localparam int RESULT_W = 12;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic done_n;
        logic [2:0] pin_cfg;
        logic [2:0] in_sel;
    } ctrl_t;

    typedef struct packed {
        logic power_on;
        logic reset;
        logic sample;
        logic [1:0] channel;
    } core_ctl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_SAMPLE,
        ST_CONVERT
    } conv_state_t;
endpackage

// ### hdl/adc_sequencer_control.sv
// control logic of a four-input 12-bit successive-approximation converter
// assumes: apb master on pclk, analog core answering sar_compare for sar_trial
//
// Functional notes
// RL1: three-bit selector picks analog input 0..3
// RL2: config field assigns low port lines analog
// RL3: config zero keeps converter powered down
// RL4: analog lines lose digital function, converter on
// RL5: start rising resets converter, done flag high
// RL6: conversion begins after start 0-1-0
// RL7: conversion end clears active-low done flag
// RL8: conversion end raises converter interrupt request
// RL9: software holds start low until done
// RL10: after config change, software pulses start
// RL11: pulse not needed when config is zero
// RL12: result split high bits, low nibble up
// RL13: result registers are read-only
// RL14: clock select divides by 2, 8, 32
// RL15: software leaves clock select top bit alone
// RL16: clock select bits 2-6 read zero
// RL17: 80 conversion clocks, first 32 sample
// RL18: both result bytes update together at done
`timescale 1ns/1ps
module adc_sequencer_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sar_compare,
    output logic [adc_pkg::RESULT_W-1:0] sar_trial,
    output adc_pkg::core_ctl_t core_ctl,
    output logic [3:0] analog_pin_en,
    output logic irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    adc_pkg::ctrl_t ctrl_q;
    logic start_prev_q;
    logic [1:0] div_sel_q;
    logic test_q;
    logic [adc_pkg::RESULT_W-1:0] result_q;
    logic irq_status_q;
    logic irq_mask_q;
    logic [4:0] div_cnt_q;
    logic [6:0] tap_q;
    logic [3:0] bit_idx_q;
    adc_pkg::conv_state_t state_q;
    logic ready_q;
    logic [31:0] rdata_q;
    logic slverr_q;

    logic wr;
    logic start_rise;
    logic start_fall;
    logic tick;
    logic [4:0] div_last;
    logic slot_end;
    logic conv_end;
    logic mapped;
    logic [7:0] rd_byte;
    logic [3:0] pin_en_d;

    assign wr = psel & penable & pwrite & ready_q;
    assign start_rise = ctrl_q.start & ~start_prev_q;
    assign start_fall = ~ctrl_q.start & start_prev_q;

    // ----------------------------------------------------------------
    // apb slave: no wait states, registered answer
    // ----------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            adc_pkg::ADDR_RESULT_LOW: begin
                rd_byte = {result_q[3:0], 4'h0}; // RL12
            end
            adc_pkg::ADDR_RESULT_HIGH: begin
                rd_byte = result_q[adc_pkg::RESULT_W-1:adc_pkg::RES_LOW_LSB]; // RL12
            end
            adc_pkg::ADDR_CONTROL: begin
                rd_byte = ctrl_q;
            end
            adc_pkg::ADDR_CLOCK_SELECT: begin
                rd_byte = {test_q, 5'h00, div_sel_q}; // RL16
            end
            adc_pkg::ADDR_IRQ_STATUS: begin
                rd_byte = {7'h00, irq_status_q};
            end
            adc_pkg::ADDR_IRQ_MASK: begin
                rd_byte = {7'h00, irq_mask_q};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= psel & ~penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            rdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slverr_q <= 1'b0;
        end else if (psel & ~penable) begin
            slverr_q <= ~mapped;
        end else if (ready_q) begin
            slverr_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= ctrl_q.start;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= adc_pkg::CONTROL_RESET;
        end else begin
            if (wr && paddr == adc_pkg::ADDR_CONTROL) begin
                ctrl_q.start <= pwdata[adc_pkg::CTRL_START_BIT];
                ctrl_q.pin_cfg <= pwdata[adc_pkg::CTRL_CFG_LSB +: 3]; // RL2
                ctrl_q.in_sel <= pwdata[adc_pkg::CTRL_SEL_LSB +: 3]; // RL1
            end
            if (start_rise) begin
                ctrl_q.done_n <= 1'b1; // RL5
            end else if (conv_end) begin
                ctrl_q.done_n <= 1'b0; // RL7
            end
        end
    end

    // ----------------------------------------------------------------
    // clock select register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_sel_q <= adc_pkg::DIV_SEL_2;
        end else if (wr && paddr == adc_pkg::ADDR_CLOCK_SELECT) begin
            div_sel_q <= pwdata[1:0]; // RL14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_q <= 1'b0;
        end else if (wr && paddr == adc_pkg::ADDR_CLOCK_SELECT) begin
            test_q <= pwdata[adc_pkg::CSEL_TEST_BIT];
        end
    end

    // ----------------------------------------------------------------
    // conversion clock divider
    // ----------------------------------------------------------------
    always_comb begin
        case (div_sel_q)
            adc_pkg::DIV_SEL_2: div_last = adc_pkg::DIV_LAST_2; // RL14
            adc_pkg::DIV_SEL_8: div_last = adc_pkg::DIV_LAST_8; // RL14
            adc_pkg::DIV_SEL_32: div_last = adc_pkg::DIV_LAST_32; // RL14
            default: div_last = adc_pkg::DIV_LAST_32;
        endcase
    end

    assign tick = (div_cnt_q >= div_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 5'h00;
        end else if (tick || state_q == adc_pkg::ST_IDLE || state_q == adc_pkg::ST_ARMED) begin
            div_cnt_q <= 5'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    assign slot_end = tick && state_q == adc_pkg::ST_CONVERT
        && (tap_q[1:0] == adc_pkg::TAPS_PER_BIT_LAST);
    assign conv_end = slot_end && (tap_q == adc_pkg::TAPS_TOTAL - 7'h01) && !start_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= adc_pkg::ST_IDLE;
            tap_q <= 7'h00;
        end else if (start_rise) begin
            state_q <= adc_pkg::ST_ARMED; // RL5
            tap_q <= 7'h00;
        end else begin
            case (state_q)
                adc_pkg::ST_IDLE: begin
                    tap_q <= 7'h00;
                end
                adc_pkg::ST_ARMED: begin
                    tap_q <= 7'h00;
                    if (start_fall) begin
                        state_q <= adc_pkg::ST_SAMPLE; // RL6
                    end
                end
                adc_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        tap_q <= tap_q + 7'h01;
                        if (tap_q == adc_pkg::TAPS_SAMPLE - 7'h01) begin
                            state_q <= adc_pkg::ST_CONVERT; // RL17
                        end
                    end
                end
                adc_pkg::ST_CONVERT: begin
                    if (tick) begin
                        tap_q <= tap_q + 7'h01;
                    end
                    if (conv_end) begin
                        state_q <= adc_pkg::ST_IDLE; // RL17
                    end
                end
                default: begin
                    state_q <= adc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // successive approximation, four taps per bit
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_trial <= '0;
        end else if (state_q == adc_pkg::ST_SAMPLE) begin
            sar_trial <= {1'b1, {(adc_pkg::RESULT_W-1){1'b0}}};
        end else if (slot_end) begin
            sar_trial[bit_idx_q] <= sar_compare;
            if (bit_idx_q != 4'h0) begin
                sar_trial[bit_idx_q - 4'h1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_idx_q <= 4'h0;
        end else if (state_q == adc_pkg::ST_SAMPLE) begin
            bit_idx_q <= 4'(adc_pkg::RESULT_W - 1);
        end else if (slot_end && bit_idx_q != 4'h0) begin
            bit_idx_q <= bit_idx_q - 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // result registers, read-only
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= '0;
        end else if (conv_end) begin
            result_q <= {sar_trial[adc_pkg::RESULT_W-1:1], sar_compare}; // RL18 RL13
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= 1'b0;
        end else if (conv_end) begin
            irq_status_q <= 1'b1; // RL8
        end else if (wr && paddr == adc_pkg::ADDR_IRQ_STATUS && pwdata[0]) begin
            irq_status_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= 1'b0;
        end else if (wr && paddr == adc_pkg::ADDR_IRQ_MASK) begin
            irq_mask_q <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (irq_status_q | conv_end) & irq_mask_q; // RL8
        end
    end

    // ----------------------------------------------------------------
    // pin assignment and core control
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < 4; i++) begin : g_pin
            assign pin_en_d[i] = ctrl_q.pin_cfg[2] || (ctrl_q.pin_cfg[1:0] > 2'(i)); // RL2
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_pin_en <= 4'h0;
        end else begin
            analog_pin_en <= pin_en_d; // RL4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ctl <= '0;
        end else begin
            core_ctl.power_on <= (ctrl_q.pin_cfg != adc_pkg::CFG_NONE); // RL3 RL4
            core_ctl.reset <= start_rise; // RL5
            core_ctl.sample <= (state_q == adc_pkg::ST_SAMPLE); // RL17
            core_ctl.channel <= ctrl_q.in_sel[1:0]; // RL1
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = slverr_q;
endmodule

// ### verif/analog_core_model.sv
// partner: analog converter core, one fixed level on each of the four inputs
// assumes: comparator answers at once for the trial code on sar_trial
`timescale 1ns/1ps
module analog_core_model (
    input wire adc_pkg::core_ctl_t core_ctl,
    input wire logic [11:0] sar_trial,
    input wire logic [47:0] levels,
    output logic sar_compare
);
    // ----------------------------------------------------------------
    // comparator, dead while powered down
    // ----------------------------------------------------------------
    always_comb begin
        if (core_ctl.power_on) begin
            sar_compare = sar_trial <= levels[12*core_ctl.channel +: 12];
        end else begin
            sar_compare = 1'b0;
        end
    end
endmodule

// ### verif/adc_sequencer_control_chk.sv
// checker: apb handshake and converter control outputs
// assumes: bound into adc_sequencer_control, single clock pclk
`timescale 1ns/1ps
module adc_sequencer_control_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire adc_pkg::core_ctl_t core_ctl,
    input wire logic [3:0] analog_pin_en
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    slverr_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    pin_map_a: assert property (analog_pin_en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("analog line set not contiguous from line 0");
    power_cfg_a: assert property (core_ctl.power_on == (analog_pin_en != 4'h0))
        else $error("power state disagrees with analog lines");
    reset_pulse_a: assert property (core_ctl.reset |=> !core_ctl.reset)
        else $error("core reset not a single pulse");
    sample_min_a: assert property ($rose(core_ctl.sample) |-> core_ctl.sample [*8])
        else $error("sampling phase too short");
endmodule

bind adc_sequencer_control adc_sequencer_control_chk chk (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .core_ctl, .analog_pin_en);

// ### verif/tb_adc_sequencer_control.sv
// testbench: register access, conversions on all inputs and dividers, abort
// assumes: analog_core_model drives the comparator, apb answers itself
`timescale 1ns/1ps
module tb_adc_sequencer_control;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, sar_compare, irq, er;
    logic [11:0] paddr = 12'h000, sar_trial;
    logic [31:0] pwdata = 32'h0, prdata;
    adc_pkg::core_ctl_t core_ctl;
    logic [3:0] analog_pin_en;
    logic [7:0] rd;
    logic [47:0] levels = {12'h3c1, 12'ha5c, 12'hfff, 12'h001};
    int num_errors = 0, cmp_count = 0, samp_n = 0;
    typedef struct packed {logic [2:0] sel, cfg; logic [1:0] div; logic msk;
        logic [3:0] pins;} row_t;
    row_t rows [5] = '{'{3'h0, 3'h1, 2'h0, 1'b1, 4'h1}, '{3'h1, 3'h2, 2'h1, 1'b0, 4'h3},
        '{3'h2, 3'h3, 2'h2, 1'b1, 4'hf & 4'h7}, '{3'h3, 3'h4, 2'h0, 1'b0, 4'hf},
        '{3'h0, 3'h7, 2'h0, 1'b1, 4'hf}};
    always #10 pclk = ~pclk;
    // counts sampling cycles since the last core reset pulse
    always @(posedge pclk) samp_n <= core_ctl.reset ? '0 : samp_n + int'(core_ctl.sample);
    adc_sequencer_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sar_compare, .sar_trial, .core_ctl, .analog_pin_en, .irq);
    analog_core_model model (.core_ctl, .sar_trial, .levels, .sar_compare);
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            conclude();
        end
        rd = prdata[7:0];
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic start_conv(input logic [7:0] c);
        apb(1, adc_pkg::ADDR_CONTROL, c | 8'h80);
        apb(0, adc_pkg::ADDR_CONTROL, 8'h00);
        chk("done_after_rise", 1, rd[6]);
        apb(1, adc_pkg::ADDR_CONTROL, c);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(0, adc_pkg::ADDR_CONTROL, 8'h00);
            n++;
        end while (rd[6] !== 1'b0 && n < 1200);
        if (n >= 1200) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic chk_res(input logic [11:0] v);
        apb(0, adc_pkg::ADDR_RESULT_HIGH, 8'h00);
        chk("result_high", v[11:4], rd);
        apb(0, adc_pkg::ADDR_RESULT_LOW, 8'h00);
        chk("result_low", {v[3:0], 4'h0}, rd);
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, adc_pkg::ADDR_CONTROL, 8'h00);
        chk("control_reset", 8'h40, rd);
        apb(0, adc_pkg::ADDR_CLOCK_SELECT, 8'h00);
        chk("clock_select_reset", 8'h00, rd);
        chk("powered_down", 5'h00, {core_ctl.power_on, analog_pin_en});
        foreach (rows[i]) begin
            apb(1, adc_pkg::ADDR_CLOCK_SELECT, {6'h00, rows[i].div});
            apb(1, adc_pkg::ADDR_IRQ_MASK, {7'h00, rows[i].msk});
            start_conv({2'b00, rows[i].cfg, rows[i].sel});
            chk("analog_lines", rows[i].pins, analog_pin_en);
            chk("channel", rows[i].sel[1:0], core_ctl.channel);
            chk("power_on", 1, core_ctl.power_on);
            wait_done();
            chk("sample_len", 32'(adc_pkg::TAPS_SAMPLE) << (2 * rows[i].div + 1), samp_n);
            chk_res(levels[12*rows[i].sel[1:0] +: 12]);
            chk("irq", rows[i].msk, irq);
            apb(0, adc_pkg::ADDR_IRQ_STATUS, 8'h00);
            chk("irq_status", 8'h01, rd);
            apb(1, adc_pkg::ADDR_IRQ_STATUS, 8'h01);
            apb(0, adc_pkg::ADDR_IRQ_STATUS, 8'h00);
            chk("irq_status_clear", 8'h00, rd);
            chk("irq_clear", 0, irq);
        end
        apb(1, adc_pkg::ADDR_RESULT_HIGH, 8'h5a);
        apb(1, adc_pkg::ADDR_RESULT_LOW, 8'h5a);
        chk_res(12'h001);
        apb(1, adc_pkg::ADDR_CLOCK_SELECT, 8'h7e);
        apb(0, adc_pkg::ADDR_CLOCK_SELECT, 8'h00);
        chk("clock_select_unused", 8'h02, rd);
        apb(0, 12'h000, 8'h00);
        chk("unmapped_error", 1, er);
        chk("unmapped_data", 8'h00, rd);
        start_conv(8'h1a);
        repeat (10) begin
            apb(0, adc_pkg::ADDR_RESULT_LOW, 8'h00);
            chk("result_hold", 8'h10, rd);
        end
        start_conv(8'h1a);
        wait_done();
        chk("sample_abort", 32'(adc_pkg::TAPS_SAMPLE) * 32, samp_n);
        chk_res(12'ha5c);
        apb(1, adc_pkg::ADDR_CONTROL, 8'h00);
        apb(0, adc_pkg::ADDR_CONTROL, 8'h00);
        chk("power_off", 5'h00, {core_ctl.power_on, analog_pin_en});
        start_conv(8'h1a);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset_outs", 32'h0, {sar_trial, core_ctl, analog_pin_en, irq, pready, pslverr});
        chk("reset_rdata", 32'h0, prdata);
        presetn <= 1'b1;
        apb(0, adc_pkg::ADDR_CONTROL, 8'h00);
        chk("control_rerun", 8'h40, rd);
        start_conv(8'h1a);
        wait_done();
        chk("sample_rerun", 32'(adc_pkg::TAPS_SAMPLE) * 2, samp_n);
        chk_res(12'ha5c);
        conclude();
    end
endmodule
